// ---- hdl/clk_ctrl.sv ----
// Summary of operation
// - four fuse bits pick the clock source
// - fuse bit one unprogrammed, zero programmed
// - wake from power-down, power-save, standby counts source clocks, holds execution
// - reset adds delay timed by watchdog oscillator
// - 512 or 8192 watchdog cycles per delay
// - shipped: RC source, longest start, divide eight
// - upper crystal bits pick oscillator range
// - crystal bit0 zero, codes 00/01: 258 clocks
// - crystal 1K settings and their reset delays
// - crystal bit0 one, codes 01-11: 16K clock wake settings
// - PLL multiplies RC clock by eight
// - PLL runs by software enable or fuse
// - lock flag set once PLL locks
// - RC and PLL off in power-down, standby
// - fast RC saturates PLL, lock is lost
// - timer may count fast clock or prescaled
// - core gated, io too except idle; async interrupts still armed
// - converter clock runs while core, io halted
// - program-memory clock follows core clock
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module clk_ctrl
#(
   parameter logic [14:0] WDT_CYC_64MS = clk_ctrl_pkg::WDT_64MS,
   parameter logic [14:0] WAKE_CK_16K = clk_ctrl_pkg::CK_16K
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [3:0] SOURCE_SELECT_FUSES,
   input wire logic [1:0] STARTUP_TIME_FUSES,
   input wire logic DIV_BY_EIGHT_FUSE,
   input wire logic PLL_CLOCK_FUSE,
   input wire logic SRC_TICK,
   input wire logic WDT_TICK,
   input wire logic RC_TICK,
   input wire logic SLEEP_REQ,
   input wire logic [2:0] SLEEP_MODE,
   input wire logic WAKE,
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic CORE_CLK_EN,
   output logic IO_CLK_EN,
   output logic PROGMEM_CLK_EN,
   output logic CONVERTER_CLK_EN,
   output logic FAST_PERIPH_CLK_EN,
   output logic RC_OSC_EN,
   output logic PLL_EN,
   output logic PLL_LOCK,
   output logic FPC_SATURATED,
   output logic CPU_HOLD,
   output logic SYS_DIV8,
   output logic [2:0] SRC_KIND,
   output logic [2:0] OSC_RANGE,
   output logic TMR_FAST_SEL,
   output logic [1:0] TMR_PRESCALE,
   output logic EXT_INT_ASYNC
)
;
   clk_ctrl_pkg::state_e state_r;
   logic [3:0] src_r;
   logic [1:0] sut_r;
   logic div8_r;
   logic pll_clock_fuse_r;
   logic [2:0] mode_r;
   logic [14:0] cnt_r;
   logic [14:0] wake_tgt;
   logic [14:0] rst_ck_tgt;
   logic [14:0] wdt_tgt;
   logic [2:0] kind;
   logic deep;
   logic pll_sw_enable_r;
   logic [7:0] rc_trim_value_r;
   logic tmr_fast_r;
   logic [1:0] tmr_pre_r;
   logic pll_run;
   logic aw_got_r;
   logic w_got_r;
   logic [3:0] awaddr_r;
   logic aw_ok_r;
   logic [7:0] wdata_r;
   logic wstrb0_r;
   logic do_wr;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic bvalid_nxt;
   logic rvalid_nxt;
   logic aw_got_nxt;
   logic w_got_nxt;
   logic [31:0] rd_word;
   logic rd_ok;

   // source decode from latched fuses
   always_comb
   begin
      if (src_r[clk_ctrl_pkg::XTAL_BIT])
      begin
         kind = clk_ctrl_pkg::KIND_XTAL;
      end
      else
      begin
         case (src_r)
            clk_ctrl_pkg::SRC_EXT: kind = clk_ctrl_pkg::KIND_EXT;
            clk_ctrl_pkg::SRC_PLL: kind = clk_ctrl_pkg::KIND_PLL;
            clk_ctrl_pkg::SRC_RC: kind = clk_ctrl_pkg::KIND_RC;
            clk_ctrl_pkg::SRC_WDOG: kind = clk_ctrl_pkg::KIND_WDOG;
            clk_ctrl_pkg::SRC_LFXTAL: kind = clk_ctrl_pkg::KIND_LFXTAL;
            default: kind = clk_ctrl_pkg::KIND_RSVD;
         endcase
      end
   end

   // start-up targets per source and start-up fuses
   always_comb
   begin
      rst_ck_tgt = clk_ctrl_pkg::CK_RESET;
      wake_tgt = clk_ctrl_pkg::CK_WAKE_SHORT;
      wdt_tgt = (sut_r[1]) ? WDT_CYC_64MS : clk_ctrl_pkg::WDT_4MS;
      if (kind == clk_ctrl_pkg::KIND_XTAL)
      begin
         case ({src_r[0], sut_r})
            3'h0:
            begin
               wake_tgt = clk_ctrl_pkg::CK_258;
               wdt_tgt = clk_ctrl_pkg::WDT_4MS;
            end
            3'h1:
            begin
               wake_tgt = clk_ctrl_pkg::CK_258;
               wdt_tgt = WDT_CYC_64MS;
            end
            3'h2:
            begin
               wake_tgt = clk_ctrl_pkg::CK_1K;
               wdt_tgt = clk_ctrl_pkg::WDT_NONE;
            end
            3'h3:
            begin
               wake_tgt = clk_ctrl_pkg::CK_1K;
               wdt_tgt = clk_ctrl_pkg::WDT_4MS;
            end
            3'h4:
            begin
               wake_tgt = clk_ctrl_pkg::CK_1K;
               wdt_tgt = WDT_CYC_64MS;
            end
            3'h5:
            begin
               wake_tgt = WAKE_CK_16K;
               wdt_tgt = clk_ctrl_pkg::WDT_NONE;
            end
            3'h6:
            begin
               wake_tgt = WAKE_CK_16K;
               wdt_tgt = clk_ctrl_pkg::WDT_4MS;
            end
            default:
            begin
               wake_tgt = WAKE_CK_16K;
               wdt_tgt = WDT_CYC_64MS;
            end
         endcase
      end
   end

   assign deep = (mode_r == clk_ctrl_pkg::SLP_PDOWN) || (mode_r == clk_ctrl_pkg::SLP_PSAVE)
      || (mode_r == clk_ctrl_pkg::SLP_STBY);

   // fuse capture after reset, shipped values meanwhile
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         src_r <= clk_ctrl_pkg::SHIP_SRC;
         sut_r <= clk_ctrl_pkg::SHIP_SUT;
         div8_r <= clk_ctrl_pkg::SHIP_DIV8;
         pll_clock_fuse_r <= clk_ctrl_pkg::SHIP_PLL_CLOCK_FUSE;
      end
      else if (state_r == clk_ctrl_pkg::ST_LOAD)
      begin
         src_r <= SOURCE_SELECT_FUSES;
         sut_r <= STARTUP_TIME_FUSES;
         div8_r <= DIV_BY_EIGHT_FUSE;
         pll_clock_fuse_r <= PLL_CLOCK_FUSE;
      end
   end

   // start-up sequencer
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         state_r <= clk_ctrl_pkg::ST_LOAD;
         cnt_r <= 15'h0000;
         mode_r <= clk_ctrl_pkg::SLP_IDLE;
      end
      else
      begin
         case (state_r)
            clk_ctrl_pkg::ST_LOAD:
            begin
               cnt_r <= 15'h0000;
               state_r <= clk_ctrl_pkg::ST_RST_CK;
            end
            clk_ctrl_pkg::ST_RST_CK:
            begin
               if (SRC_TICK)
               begin
                  cnt_r <= cnt_r + 15'h0001;
                  if (cnt_r == rst_ck_tgt - 15'h0001)
                  begin
                     cnt_r <= 15'h0000;
                     state_r <= (wdt_tgt == 15'h0000) ? clk_ctrl_pkg::ST_RUN : clk_ctrl_pkg::ST_RST_WDT;
                  end
               end
            end
            clk_ctrl_pkg::ST_RST_WDT:
            begin
               if (WDT_TICK)
               begin
                  cnt_r <= cnt_r + 15'h0001;
                  if (cnt_r == wdt_tgt - 15'h0001)
                  begin
                     cnt_r <= 15'h0000;
                     state_r <= clk_ctrl_pkg::ST_RUN;
                  end
               end
            end
            clk_ctrl_pkg::ST_RUN:
            begin
               if (SLEEP_REQ)
               begin
                  mode_r <= SLEEP_MODE;
                  state_r <= clk_ctrl_pkg::ST_SLEEP;
               end
            end
            clk_ctrl_pkg::ST_SLEEP:
            begin
               if (WAKE)
               begin
                  cnt_r <= 15'h0000;
                  state_r <= deep ? clk_ctrl_pkg::ST_WAKE : clk_ctrl_pkg::ST_RUN;
               end
            end
            clk_ctrl_pkg::ST_WAKE:
            begin
               if (SRC_TICK)
               begin
                  cnt_r <= cnt_r + 15'h0001;
                  if (cnt_r == wake_tgt - 15'h0001)
                  begin
                     cnt_r <= 15'h0000;
                     state_r <= clk_ctrl_pkg::ST_RUN;
                  end
               end
            end
            default:
            begin
               cnt_r <= 15'h0000;
               state_r <= clk_ctrl_pkg::ST_LOAD;
            end
         endcase
      end
   end

   // clock domain gates
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         CORE_CLK_EN <= 1'b0;
         PROGMEM_CLK_EN <= 1'b0;
         IO_CLK_EN <= 1'b0;
         CONVERTER_CLK_EN <= 1'b0;
         EXT_INT_ASYNC <= 1'b1;
         CPU_HOLD <= 1'b1;
         RC_OSC_EN <= 1'b1;
      end
      else
      begin
         CORE_CLK_EN <= state_r == clk_ctrl_pkg::ST_RUN;
         PROGMEM_CLK_EN <= state_r == clk_ctrl_pkg::ST_RUN;
         IO_CLK_EN <= (state_r == clk_ctrl_pkg::ST_RUN) || ((state_r == clk_ctrl_pkg::ST_SLEEP)
            && (mode_r == clk_ctrl_pkg::SLP_IDLE));
         EXT_INT_ASYNC <= state_r != clk_ctrl_pkg::ST_RUN;
         CONVERTER_CLK_EN <= (state_r == clk_ctrl_pkg::ST_RUN) || ((state_r == clk_ctrl_pkg::ST_SLEEP)
            && !deep);
         CPU_HOLD <= state_r != clk_ctrl_pkg::ST_RUN;
         RC_OSC_EN <= !((state_r == clk_ctrl_pkg::ST_SLEEP) && ((mode_r == clk_ctrl_pkg::SLP_PDOWN)
            || (mode_r == clk_ctrl_pkg::SLP_STBY)));
      end
   end

   assign pll_run = (pll_sw_enable_r || (pll_clock_fuse_r == clk_ctrl_pkg::FUSE_PROGRAMMED)) && RC_OSC_EN;

   // pll, prescale and configuration outputs
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         PLL_EN <= 1'b0;
         FAST_PERIPH_CLK_EN <= 1'b0;
         SYS_DIV8 <= 1'b1;
         SRC_KIND <= clk_ctrl_pkg::KIND_RC;
         OSC_RANGE <= 3'h0;
         TMR_FAST_SEL <= 1'b0;
         TMR_PRESCALE <= 2'h0;
      end
      else
      begin
         PLL_EN <= pll_run;
         FAST_PERIPH_CLK_EN <= PLL_LOCK || FPC_SATURATED;
         SYS_DIV8 <= div8_r == clk_ctrl_pkg::FUSE_PROGRAMMED;
         SRC_KIND <= kind;
         OSC_RANGE <= (kind == clk_ctrl_pkg::KIND_XTAL) ? src_r[3:1] : 3'h0;
         TMR_FAST_SEL <= tmr_fast_r && PLL_EN;
         TMR_PRESCALE <= tmr_pre_r;
      end
   end

   pll_lock_model u_pll
   (
      .clk(CLK),
      .reset_n(RESET_N),
      .run(PLL_EN),
      .ref_tick(RC_TICK),
      .trim(rc_trim_value_r),
      .locked(PLL_LOCK),
      .saturated(FPC_SATURATED)
   );

   // register slave handshakes
   assign aw_hs = AWVALID && AWREADY;
   assign w_hs = WVALID && WREADY;
   assign ar_hs = ARVALID && ARREADY;
   assign do_wr = aw_got_r && w_got_r && !BVALID;
   assign aw_got_nxt = (aw_got_r || aw_hs) && !do_wr;
   assign w_got_nxt = (w_got_r || w_hs) && !do_wr;
   assign bvalid_nxt = do_wr || (BVALID && !BREADY);
   assign rvalid_nxt = ar_hs || (RVALID && !RREADY);

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= clk_ctrl_pkg::RESP_OKAY;
         awaddr_r <= 4'h0;
         aw_ok_r <= 1'b0;
         wdata_r <= 8'h00;
         wstrb0_r <= 1'b0;
      end
      else
      begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         AWREADY <= !aw_got_nxt && !bvalid_nxt;
         WREADY <= !w_got_nxt && !bvalid_nxt;
         BVALID <= bvalid_nxt;
         if (aw_hs)
         begin
            awaddr_r <= AWADDR[3:0];
            aw_ok_r <= (AWADDR[31:4] == 28'h0000000) && (AWADDR[1:0] == 2'h0);
         end
         if (w_hs)
         begin
            wdata_r <= WDATA[7:0];
            wstrb0_r <= WSTRB[0];
         end
         if (do_wr)
         begin
            BRESP <= aw_ok_r ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR;
         end
      end
   end

   // software-written control fields
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         pll_sw_enable_r <= 1'b0;
         rc_trim_value_r <= clk_ctrl_pkg::TRIM_RST;
         tmr_fast_r <= 1'b0;
         tmr_pre_r <= 2'h0;
      end
      else if (do_wr && aw_ok_r && wstrb0_r)
      begin
         case (awaddr_r)
            clk_ctrl_pkg::ADDR_PLL_CSR: pll_sw_enable_r <= wdata_r[clk_ctrl_pkg::PLL_SW_ENABLE_BIT];
            clk_ctrl_pkg::ADDR_TRIM: rc_trim_value_r <= wdata_r;
            clk_ctrl_pkg::ADDR_TMR_CLK:
            begin
               tmr_fast_r <= wdata_r[0];
               tmr_pre_r <= wdata_r[2:1];
            end
            default: tmr_pre_r <= tmr_pre_r;
         endcase
      end
   end

   // read decode
   always_comb
   begin
      rd_word = 32'h00000000;
      rd_ok = (ARADDR[31:4] == 28'h0000000) && (ARADDR[1:0] == 2'h0);
      case (ARADDR[3:0])
         clk_ctrl_pkg::ADDR_PLL_CSR:
         begin
            rd_word[clk_ctrl_pkg::LOCK_BIT] = PLL_LOCK;
            rd_word[clk_ctrl_pkg::PLL_SW_ENABLE_BIT] = pll_sw_enable_r;
         end
         clk_ctrl_pkg::ADDR_TRIM: rd_word[7:0] = rc_trim_value_r;
         clk_ctrl_pkg::ADDR_TMR_CLK: rd_word[2:0] = {tmr_pre_r, tmr_fast_r};
         clk_ctrl_pkg::ADDR_STATUS: rd_word[15:0] = {1'b0, FPC_SATURATED, pll_clock_fuse_r, div8_r, state_r, sut_r, src_r};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= clk_ctrl_pkg::RESP_OKAY;
      end
      else
      begin
         ARREADY <= !rvalid_nxt;
         RVALID <= rvalid_nxt;
         if (ar_hs)
         begin
            RDATA <= rd_ok ? rd_word : 32'h00000000;
            RRESP <= rd_ok ? clk_ctrl_pkg::RESP_OKAY : clk_ctrl_pkg::RESP_SLVERR;
         end
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   a_core_gate_run: assert property ((state_r != clk_ctrl_pkg::ST_RUN) |=> !CORE_CLK_EN)
      else $error("core clock enabled outside run");
   a_progmem_core_pair: assert property (PROGMEM_CLK_EN == CORE_CLK_EN)
      else $error("progmem clock not paired with core clock");
   a_rc_off_deep: assert property ((state_r == clk_ctrl_pkg::ST_SLEEP) && (mode_r == clk_ctrl_pkg::SLP_STBY)
      |=> !RC_OSC_EN ##1 !PLL_EN)
      else $error("rc or pll running in standby");
   a_sat_no_lock: assert property (FPC_SATURATED |-> !PLL_LOCK)
      else $error("lock flag with saturated pll");
   a_wake_restart: assert property ($rose(state_r == clk_ctrl_pkg::ST_WAKE) |-> cnt_r == 15'h0000)
      else $error("wake counter not restarted");
   a_wdt_done_count: assert property ((state_r == clk_ctrl_pkg::ST_RST_WDT) ##1 (state_r == clk_ctrl_pkg::ST_RUN)
      |-> $past(WDT_TICK) && ($past(cnt_r) == wdt_tgt - 15'h0001))
      else $error("reset delay ended early");
   a_wake_hold_cpu: assert property ((state_r == clk_ctrl_pkg::ST_WAKE) [*2] |-> CPU_HOLD)
      else $error("cpu released during wake count");
   a_adc_runs_nr: assert property ((state_r == clk_ctrl_pkg::ST_SLEEP) && (mode_r == clk_ctrl_pkg::SLP_ADCNR)
      |=> CONVERTER_CLK_EN && !IO_CLK_EN && EXT_INT_ASYNC)
      else $error("converter clock not kept in noise reduction");
   a_div8_fuse: assert property ((state_r == clk_ctrl_pkg::ST_RST_CK) |-> ##1 SYS_DIV8 == !div8_r)
      else $error("divide fuse polarity wrong");
   a_unmapped_err: assert property (ar_hs && !rd_ok |=> RVALID && RRESP == clk_ctrl_pkg::RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule

// ---- hdl/clk_ctrl_pkg.sv ----
package clk_ctrl_pkg;
   // fuse encodings, 1 = unprogrammed, 0 = programmed
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic [3:0] SRC_EXT = 4'h0;
   localparam logic [3:0] SRC_PLL = 4'h1;
   localparam logic [3:0] SRC_RC = 4'h2;
   localparam logic [3:0] SRC_WDOG = 4'h4;
   localparam logic [3:0] SRC_LFXTAL = 4'h6;
   localparam int XTAL_BIT = 3;
   // as-delivered fuse values
   localparam logic [3:0] SHIP_SRC = 4'h2;
   localparam logic [1:0] SHIP_SUT = 2'h2;
   localparam logic SHIP_DIV8 = 1'b0;
   localparam logic SHIP_PLL_CLOCK_FUSE = 1'b1;
   // source kinds
   localparam logic [2:0] KIND_EXT = 3'h0;
   localparam logic [2:0] KIND_PLL = 3'h1;
   localparam logic [2:0] KIND_RC = 3'h2;
   localparam logic [2:0] KIND_WDOG = 3'h3;
   localparam logic [2:0] KIND_LFXTAL = 3'h4;
   localparam logic [2:0] KIND_XTAL = 3'h5;
   localparam logic [2:0] KIND_RSVD = 3'h7;
   // start-up counts
   localparam int CNT_W = 15;
   localparam logic [14:0] CK_WAKE_SHORT = 15'h0006;
   localparam logic [14:0] CK_258 = 15'h0102;
   localparam logic [14:0] CK_1K = 15'h0400;
   localparam logic [14:0] CK_16K = 15'h4000;
   localparam logic [14:0] CK_RESET = 15'h000E;
   localparam logic [14:0] WDT_NONE = 15'h0000;
   localparam logic [14:0] WDT_4MS = 15'h0200;
   localparam logic [14:0] WDT_64MS = 15'h2000;
   localparam logic [7:0] PLL_LOCK_TICKS = 8'h40;
   // sleep modes
   localparam logic [2:0] SLP_IDLE = 3'h0;
   localparam logic [2:0] SLP_ADCNR = 3'h1;
   localparam logic [2:0] SLP_PDOWN = 3'h2;
   localparam logic [2:0] SLP_PSAVE = 3'h3;
   localparam logic [2:0] SLP_STBY = 3'h6;
   // register map
   localparam logic [3:0] ADDR_PLL_CSR = 4'h0;
   localparam logic [3:0] ADDR_TRIM = 4'h4;
   localparam logic [3:0] ADDR_TMR_CLK = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam int LOCK_BIT = 0;
   localparam int PLL_SW_ENABLE_BIT = 1;
   localparam logic [7:0] TRIM_RST = 8'h80;
   localparam logic [7:0] TRIM_8MHZ_MAX = 8'h90;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [5:0] {
      ST_LOAD = 6'h01,
      ST_RST_CK = 6'h02,
      ST_RST_WDT = 6'h04,
      ST_RUN = 6'h08,
      ST_SLEEP = 6'h10,
      ST_WAKE = 6'h20
   } state_e;
endpackage

// ---- hdl/pll_lock_model.sv ----
`timescale 1ns/10ps
module pll_lock_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic ref_tick,
   input wire logic [7:0] trim,
   output logic locked,
   output logic saturated
)
;
   logic [7:0] cnt_r;
   logic over;
   assign over = trim > clk_ctrl_pkg::TRIM_8MHZ_MAX;
   // counts reference edges until lock
   always_ff @(posedge clk)
   begin
      if (!reset_n || !run || over)
      begin
         cnt_r <= 8'h00;
         locked <= 1'b0;
      end
      else if (ref_tick && !locked)
      begin
         if (cnt_r == clk_ctrl_pkg::PLL_LOCK_TICKS - 8'h01)
         begin
            locked <= 1'b1;
         end
         cnt_r <= cnt_r + 8'h01;
      end
   end
   // output pinned at its ceiling when ref runs too fast
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         saturated <= 1'b0;
      end
      else
      begin
         saturated <= run && over;
      end
   end
endmodule

// ---- verification/clk_ctrl_bench.sv ----
`timescale 1ns/10ps
module clk_ctrl_bench;
   logic CLK = 0, RESET_N = 0, DIV_BY_EIGHT_FUSE = 1, PLL_CLOCK_FUSE = 1;
   logic SRC_TICK = 0, WDT_TICK = 0, RC_TICK = 0, SLEEP_REQ = 0, WAKE = 0;
   logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic [3:0] SOURCE_SELECT_FUSES = 4'h2, WSTRB = 4'hF;
   logic [1:0] STARTUP_TIME_FUSES = 2'h2;
   logic [2:0] SLEEP_MODE = 3'h0;
   logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CORE_CLK_EN, IO_CLK_EN, PROGMEM_CLK_EN;
   logic CONVERTER_CLK_EN, FAST_PERIPH_CLK_EN, RC_OSC_EN, PLL_EN, PLL_LOCK, FPC_SATURATED;
   logic CPU_HOLD, SYS_DIV8, TMR_FAST_SEL, EXT_INT_ASYNC;
   logic [1:0] BRESP, RRESP, TMR_PRESCALE, r;
   logic [2:0] SRC_KIND, OSC_RANGE;
   logic [31:0] RDATA, d, v;
   int fails = 0, check_count = 0;
   integer seed = 32'h9AA34EC2;
   localparam logic [2:0] KT [8] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h7, 3'h4, 3'h7};
   logic [3:0] cs [3] = '{4'h2, 4'h8, 4'h9};
   int nw [3] = '{16, 0, 512};
   logic [2:0] sm [5] = '{clk_ctrl_pkg::SLP_IDLE, clk_ctrl_pkg::SLP_ADCNR, clk_ctrl_pkg::SLP_PSAVE,
      clk_ctrl_pkg::SLP_PDOWN, clk_ctrl_pkg::SLP_STBY};

   always #2 CLK = ~CLK;

   clk_ctrl #(.WDT_CYC_64MS(15'h0010), .WAKE_CK_16K(15'h0014)) dut (.CLK, .RESET_N, .SOURCE_SELECT_FUSES,
      .STARTUP_TIME_FUSES, .DIV_BY_EIGHT_FUSE, .PLL_CLOCK_FUSE, .SRC_TICK, .WDT_TICK, .RC_TICK, .SLEEP_REQ,
      .SLEEP_MODE, .WAKE, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
      .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .CORE_CLK_EN, .IO_CLK_EN,
      .PROGMEM_CLK_EN, .CONVERTER_CLK_EN, .FAST_PERIPH_CLK_EN, .RC_OSC_EN, .PLL_EN, .PLL_LOCK, .FPC_SATURATED,
      .CPU_HOLD, .SYS_DIV8, .SRC_KIND, .OSC_RANGE, .TMR_FAST_SEL, .TMR_PRESCALE, .EXT_INT_ASYNC);

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // one pulse of the chosen oscillator every two clocks
   task tick(input int k, input int n);
      repeat (n)
      begin
         @(posedge CLK);
         SRC_TICK <= (k == 0);
         WDT_TICK <= (k == 1);
         RC_TICK <= (k == 2);
         @(posedge CLK);
         {SRC_TICK, WDT_TICK, RC_TICK} <= 3'h0;
      end
   endtask

   task boot(input logic [3:0] s, input logic dv, input logic pk);
      @(posedge CLK);
      RESET_N <= 1'b0;
      SOURCE_SELECT_FUSES <= s;
      DIV_BY_EIGHT_FUSE <= dv;
      PLL_CLOCK_FUSE <= pk;
      repeat (10) @(posedge CLK);
      chk(SRC_KIND, 3'h2, "shipped source");
      chk(SYS_DIV8, 1'b1, "shipped divide");
      RESET_N <= 1'b1;
      cyc(3);
   endtask

   task run_wait;
      int n;
      n = 0;
      while (CPU_HOLD !== 1'b0 && n < 20)
      begin
         @(posedge CLK);
         n++;
      end
      cyc(2);
      chk(CPU_HOLD, 1'b0, "hold stuck");
      chk(CORE_CLK_EN, 1'b1, "core gate");
      chk(PROGMEM_CLK_EN, 1'b1, "progmem gate");
   endtask

   task wr(input logic [31:0] a, input logic [31:0] val);
      logic pa, pw;
      pa = 1;
      pw = 1;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= val;
      {AWVALID, WVALID, BREADY} <= 3'h7;
      while (pa || pw)
      begin
         @(posedge CLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         pa = pa && !AWREADY;
         pw = pw && !WREADY;
      end
      do @(posedge CLK); while (BVALID !== 1'b1);
      r = BRESP;
      BREADY <= 1'b0;
   endtask

   task rd(input logic [31:0] a);
      @(posedge CLK);
      ARADDR <= a;
      {ARVALID, RREADY} <= 2'h3;
      do @(posedge CLK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      do @(posedge CLK); while (RVALID !== 1'b1);
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
   endtask

   initial
   begin
      #100000;
      fails++;
      finish_test;
   end

   initial
   begin
      for (int c = 0; c < 16; c++)
      begin
         boot(c[3:0], c[1], c[0]);
         chk(SRC_KIND, c[3] ? 3'h5 : KT[c[2:0]], "source kind");
         chk(OSC_RANGE, c[3] ? c[3:1] : 3'h0, "osc range");
         chk(SYS_DIV8, !c[1], "divide fuse");
         chk(PLL_EN, !c[0], "pll fuse");
      end
      $display("test decode done");
      for (int i = 0; i < 3; i++)
      begin
         boot(cs[i], 1'b0, 1'b1);
         tick(0, 10);
         boot(cs[i], 1'b0, 1'b1);
         tick(0, nw[i] ? 14 : 13);
         tick(1, nw[i] ? nw[i] - 1 : 0);
         cyc(4);
         chk(CPU_HOLD, 1'b1, "early release");
         chk(CORE_CLK_EN, 1'b0, "early core gate");
         tick(nw[i] ? 1 : 0, 1);
         run_wait;
      end
      $display("test startup done");
      wr(32'h0, 32'h2);
      cyc(3);
      chk(PLL_EN, 1'b1, "pll enable");
      tick(2, 63);
      cyc(3);
      chk(PLL_LOCK, 1'b0, "early lock");
      tick(2, 1);
      cyc(3);
      chk(PLL_LOCK, 1'b1, "no lock");
      chk(FAST_PERIPH_CLK_EN, 1'b1, "fast clock");
      rd(32'h0);
      chk(d, 32'h3, "csr read");
      wr(32'h8, 32'h7);
      cyc(3);
      chk(TMR_FAST_SEL, 1'b1, "timer fast");
      chk(TMR_PRESCALE, 2'h3, "timer prescale");
      rd(32'h4);
      chk(d, 32'h80, "trim reset");
      repeat (4)
      begin
         v = {$random(seed)} % 145;
         wr(32'h4, v);
         rd(32'h4);
         chk(d, v, "trim readback");
         chk(FPC_SATURATED, 1'b0, "false saturation");
      end
      wr(32'h4, 32'h91);
      cyc(3);
      chk(FPC_SATURATED, 1'b1, "saturation");
      chk(PLL_LOCK, 1'b0, "lock kept");
      wr(32'h4, 32'h80);
      rd(32'h10);
      chk(r, clk_ctrl_pkg::RESP_SLVERR, "unmapped read");
      chk(d, 32'h0, "unmapped data");
      wr(32'h14, 32'h1);
      chk(r, clk_ctrl_pkg::RESP_SLVERR, "unmapped write");
      rd(32'h4);
      chk(d, 32'h80, "unmapped write landed");
      $display("test register done");
      for (int i = 0; i < 5; i++)
      begin
         @(posedge CLK);
         SLEEP_MODE <= sm[i];
         SLEEP_REQ <= 1'b1;
         @(posedge CLK);
         SLEEP_REQ <= 1'b0;
         cyc(3);
         chk(CORE_CLK_EN, 1'b0, "core asleep");
         chk(PROGMEM_CLK_EN, 1'b0, "progmem asleep");
         chk(EXT_INT_ASYNC, 1'b1, "async wake");
         chk(RC_OSC_EN, i < 3, "rc in sleep");
         chk(PLL_EN, i < 3, "pll in sleep");
         chk(CONVERTER_CLK_EN, i < 2, "converter");
         chk(IO_CLK_EN, i == 0, "io in sleep");
         @(posedge CLK);
         WAKE <= 1'b1;
         @(posedge CLK);
         WAKE <= 1'b0;
         if (i > 1)
         begin
            tick(0, 19);
            cyc(3);
            chk(CPU_HOLD, 1'b1, "early wake");
            tick(0, 1);
         end
         run_wait;
      end
      $display("test sleep done");
      finish_test;
   end
endmodule
